// [logic/szbt_consts.svh]
`ifndef SZBT_CONSTS_SVH
`define SZBT_CONSTS_SVH

// ----------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------
`define SZBT_OFS_ZONE0      8'h00
`define SZBT_OFS_ZONE1      8'h04
`define SZBT_OFS_ZONE2      8'h08
`define SZBT_OFS_IOZONE     8'h0c
`define SZBT_OFS_STATUS     8'h10

// ----------------------------------------------------------------------
// timing configuration field positions
// ----------------------------------------------------------------------
`define SZBT_WAIT_MSB       2
`define SZBT_WAIT_LSB       0
`define SZBT_HOLD_MSB       4
`define SZBT_HOLD_LSB       3
`define SZBT_BIT_BURST_EN   5
`define SZBT_BIT_BURST_WAIT 6
`define SZBT_BIT_WIDTH      7
`define SZBT_BIT_IDLE_AFTER 9
`define SZBT_BIT_IDLE_BEFORE 10
`define SZBT_BIT_FAST_READ  11
`define SZBT_BIT_EARLY_WR   12

// ----------------------------------------------------------------------
// reset values and writable masks
// ----------------------------------------------------------------------
`define SZBT_RST_ZONE0      16'h069f
`define SZBT_RST_ZONE1      16'h069f
`define SZBT_RST_ZONE2      16'h069f
`define SZBT_RST_IOZONE     16'h069f
`define SZBT_MASK_ZONE0     16'h1eff
`define SZBT_MASK_ZONE      16'h0eff

// ----------------------------------------------------------------------
// cycle counts
// ----------------------------------------------------------------------
`define SZBT_BASE_FAST      2'h1
`define SZBT_BASE_NORMAL    2'h2
`define SZBT_FLASH_RD_ADD   4'h1
`define SZBT_FLASH_LATE_ADD 4'h1
`define SZBT_FLASH_EARLY_ADD 4'h2
`define SZBT_FLASH_FAST_WR  4'h1
`define SZBT_PERIPH_WAITS   4'h1

`endif

// [logic/szbt_pkg.sv]
package szbt_pkg;

    // bus cycle phases, one-hot
    typedef enum logic [6:0] {
        PH_IDLE  = 7'h01,
        PH_POST  = 7'h02,
        PH_PRE   = 7'h04,
        PH_BASE  = 7'h08,
        PH_WAIT  = 7'h10,
        PH_HOLD  = 7'h20,
        PH_BURST = 7'h40
    } szbt_phase_t;

    // address zones
    typedef enum logic [2:0] {
        ZN_NONE   = 3'h0,
        ZN_FLASH  = 3'h1,
        ZN_RAM    = 3'h2,
        ZN_PERIPH = 3'h3,
        ZN_IO     = 3'h4,
        ZN_ZONE1  = 3'h5,
        ZN_ZONE2  = 3'h6
    } szbt_zone_t;

    typedef struct packed {
        logic        valid;
        logic [23:0] addr;
        logic        write;
        logic        wide;
    } szbt_cpu_req_t;

    typedef struct packed {
        logic zone1_select;
        logic zone2_select;
        logic ext_read;
        logic ext_write;
        logic upper_byte;
        logic idle_cycle;
        logic busy;
    } szbt_bus_out_t;

    typedef struct packed {
        szbt_zone_t zone;
        logic       write;
        logic [1:0] base;
        logic [3:0] waits;
        logic [1:0] holds;
        logic       two_xfer;
        logic       burst;
        logic       bwait;
        logic       pre_cfg;
        logic       pre_always;
        logic       post_cfg;
    } szbt_plan_t;

    typedef struct packed {
        szbt_phase_t phase;
        logic [3:0]  cnt;
        logic        second;
        logic        done;
    } szbt_seq_t;

    typedef struct packed {
        szbt_phase_t   phase;
        logic [3:0]    cnt;
        logic          second;
        szbt_plan_t    plan;
        szbt_zone_t    last_zone;
        logic          last_post;
        logic [15:0]   cfg0;
        logic [15:0]   cfg1;
        logic [15:0]   cfg2;
        logic [15:0]   cfgio;
        logic          aw_held;
        logic [7:0]    awaddr;
        logic          w_held;
        logic [15:0]   wdata;
        logic [1:0]    wstrb;
        logic          awready;
        logic          wready;
        logic          bvalid;
        logic [1:0]    bresp;
        logic          arready;
        logic          rvalid;
        logic [31:0]   rdata;
        logic [1:0]    rresp;
        logic          cpu_done;
        szbt_bus_out_t bus;
    } szbt_state_t;

endpackage

// [logic/szbt_top.sv]
`timescale 1ns/1ps
`include "szbt_consts.svh"

module szbt_top #(
    parameter logic [23:0] ZONE1_FIRST = 24'h100000,
    parameter logic [23:0] ZONE1_LAST  = 24'h1fffff,
    parameter logic [23:0] ZONE2_FIRST = 24'h200000,
    parameter logic [23:0] ZONE2_LAST  = 24'h3fffff
) (
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    input  wire logic [7:0]              s_axi_awaddr,
    input  wire logic                    s_axi_awvalid,
    output logic                         s_axi_awready,
    input  wire logic [31:0]             s_axi_wdata,
    input  wire logic [3:0]              s_axi_wstrb,
    input  wire logic                    s_axi_wvalid,
    output logic                         s_axi_wready,
    output logic [1:0]                   s_axi_bresp,
    output logic                         s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    input  wire logic [7:0]              s_axi_araddr,
    input  wire logic                    s_axi_arvalid,
    output logic                         s_axi_arready,
    output logic [31:0]                  s_axi_rdata,
    output logic [1:0]                   s_axi_rresp,
    output logic                         s_axi_rvalid,
    input  wire logic                    s_axi_rready,
    input  wire szbt_pkg::szbt_cpu_req_t cpu_req,
    output logic                         cpu_done,
    output szbt_pkg::szbt_bus_out_t      bus_out
);
    import szbt_pkg::*;

    // ------------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------------
    if (ZONE1_FIRST > ZONE1_LAST || ZONE2_FIRST > ZONE2_LAST) begin : g_bad_range
        $error("zone range first above last");
    end
    if (ZONE1_LAST >= ZONE2_FIRST && ZONE2_LAST >= ZONE1_FIRST) begin : g_overlap
        $error("zone 1 and zone 2 ranges overlap");
    end

    szbt_state_t st;
    szbt_state_t nx;

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    function automatic szbt_zone_t zone_of(input logic [23:0] a);
        szbt_zone_t z;
        z = ZN_NONE;
        if (a <= 24'h03ffff || (a >= 24'h0e0000 && a <= 24'h0e1fff)) begin
            z = ZN_FLASH;
        end else if ((a >= 24'h0e8000 && a <= 24'h0e91ff) ||
                     (a >= 24'h0ec000 && a <= 24'h0eebff)) begin
            z = ZN_RAM;
        end else if (a >= 24'hfffb00 && a <= 24'hfffbff) begin
            z = ZN_IO;
        end else if ((a >= 24'h0ef000 && a <= 24'h0ef1ff) ||
                     (a >= 24'hff0000 && a <= 24'hfffaff)) begin
            z = ZN_PERIPH;
        end else if (a >= ZONE1_FIRST && a <= ZONE1_LAST) begin
            z = ZN_ZONE1;
        end else if (a >= ZONE2_FIRST && a <= ZONE2_LAST) begin
            z = ZN_ZONE2;
        end
        return z;
    endfunction

    // ------------------------------------------------------------------
    // per-access timing plan
    // ------------------------------------------------------------------
    function automatic szbt_plan_t plan_of(input szbt_cpu_req_t r, input szbt_state_t s);
        szbt_plan_t p;
        logic [15:0] c;
        logic        fast;
        p = '0;
        p.zone = zone_of(r.addr);
        p.write = r.write;
        p.base = `SZBT_BASE_FAST;
        unique case (p.zone)
            ZN_ZONE1: c = s.cfg1;
            ZN_ZONE2: c = s.cfg2;
            ZN_IO:    c = s.cfgio;
            default:  c = s.cfg0;
        endcase
        fast = c[`SZBT_BIT_FAST_READ];
        if (p.zone == ZN_FLASH) begin
            p.pre_cfg = c[`SZBT_BIT_IDLE_BEFORE];
            p.post_cfg = c[`SZBT_BIT_IDLE_AFTER];
            if (fast && r.write) begin
                p.waits = `SZBT_FLASH_FAST_WR;
            end else if (!fast && !r.write) begin
                p.waits = 4'({1'b0, c[`SZBT_WAIT_MSB:`SZBT_WAIT_LSB]})
                          + `SZBT_FLASH_RD_ADD;
                p.holds = c[`SZBT_HOLD_MSB:`SZBT_HOLD_LSB];
            end else if (!fast) begin
                p.waits = 4'({1'b0, c[`SZBT_WAIT_MSB:`SZBT_WAIT_LSB]})
                          + (c[`SZBT_BIT_EARLY_WR] ? `SZBT_FLASH_EARLY_ADD
                                                   : `SZBT_FLASH_LATE_ADD);
                p.holds = c[`SZBT_HOLD_MSB:`SZBT_HOLD_LSB];
            end
            // fast read keeps base of one, no waits
        end else if (p.zone == ZN_PERIPH) begin
            p.waits = `SZBT_PERIPH_WAITS;
            p.pre_always = 1'b1;
        end else if (p.zone == ZN_ZONE1 || p.zone == ZN_ZONE2 || p.zone == ZN_IO) begin
            p.base = (fast && !r.write) ? `SZBT_BASE_FAST : `SZBT_BASE_NORMAL;
            p.waits = fast ? 4'h0
                           : {1'b0, c[`SZBT_WAIT_MSB:`SZBT_WAIT_LSB]};
            p.holds = fast ? 2'h0 : c[`SZBT_HOLD_MSB:`SZBT_HOLD_LSB];
            p.two_xfer = r.wide && !c[`SZBT_BIT_WIDTH];
            p.burst = p.two_xfer && !r.write && !fast && c[`SZBT_BIT_BURST_EN];
            p.bwait = p.burst && c[`SZBT_BIT_BURST_WAIT];
            p.pre_cfg = c[`SZBT_BIT_IDLE_BEFORE];
            p.post_cfg = c[`SZBT_BIT_IDLE_AFTER];
        end
        // ram and unmapped keep the single base cycle
        return p;
    endfunction

    // ------------------------------------------------------------------
    // phase sequencing after a phase ends (from: 0 base, 1 wait, 2 hold, 3 burst)
    // ------------------------------------------------------------------
    function automatic szbt_seq_t step(input szbt_plan_t p, input logic second,
                                       input logic [1:0] from);
        szbt_seq_t s;
        s.phase = PH_IDLE;
        s.cnt = 4'h0;
        s.second = second;
        s.done = 1'b0;
        if (from == 2'd0 && p.waits != 4'h0) begin
            s.phase = PH_WAIT;
            s.cnt = p.waits - 4'h1;
        end else if (from <= 2'd1 && p.holds != 2'h0) begin
            s.phase = PH_HOLD;
            s.cnt = {2'h0, p.holds - 2'h1};
        end else if (p.two_xfer && !second) begin
            s.second = 1'b1;
            if (p.burst) begin
                s.phase = PH_BURST;
                s.cnt = {3'h0, p.bwait};
            end else begin
                s.phase = PH_BASE;
                s.cnt = {2'h0, p.base - 2'h1};
            end
        end else begin
            s.done = 1'b1;
        end
        return s;
    endfunction

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        szbt_plan_t  p;
        szbt_seq_t   sq;
        logic        changed;
        logic        active;
        logic        offchip;
        logic [15:0] mask;
        logic [15:0] wr;
        p = plan_of(cpu_req, st);
        sq = '0;
        sq.phase = PH_IDLE;
        changed = 1'b0;
        active = 1'b0;
        offchip = 1'b0;
        mask = 16'h0000;
        wr = 16'h0000;
        nx = st;
        nx.cpu_done = 1'b0;

        // write address and data taken in either order
        if (s_axi_awvalid && st.awready) begin
            nx.aw_held = 1'b1;
            nx.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st.wready) begin
            nx.w_held = 1'b1;
            nx.wdata = s_axi_wdata[15:0];
            nx.wstrb = s_axi_wstrb[1:0];
        end
        if (st.bvalid && s_axi_bready) begin
            nx.bvalid = 1'b0;
        end
        if (st.aw_held && st.w_held && !st.bvalid) begin
            nx.aw_held = 1'b0;
            nx.w_held = 1'b0;
            nx.bvalid = 1'b1;
            nx.bresp = 2'h0;
            mask = {{8{st.wstrb[1]}}, {8{st.wstrb[0]}}};
            unique case (st.awaddr)
                `SZBT_OFS_ZONE0: begin
                    wr = mask & `SZBT_MASK_ZONE0;
                    nx.cfg0 = (st.cfg0 & ~wr) | (st.wdata & wr);
                end
                `SZBT_OFS_ZONE1: begin
                    wr = mask & `SZBT_MASK_ZONE;
                    nx.cfg1 = (st.cfg1 & ~wr) | (st.wdata & wr);
                end
                `SZBT_OFS_ZONE2: begin
                    wr = mask & `SZBT_MASK_ZONE;
                    nx.cfg2 = (st.cfg2 & ~wr) | (st.wdata & wr);
                end
                `SZBT_OFS_IOZONE: begin
                    wr = mask & `SZBT_MASK_ZONE;
                    nx.cfgio = (st.cfgio & ~wr) | (st.wdata & wr);
                end
                `SZBT_OFS_STATUS: nx.bresp = 2'h0;
                default:          nx.bresp = 2'h2;
            endcase
        end
        nx.awready = !nx.aw_held;
        nx.wready = !nx.w_held;

        // read channel
        if (st.rvalid && s_axi_rready) begin
            nx.rvalid = 1'b0;
        end
        if (s_axi_arvalid && st.arready) begin
            nx.rvalid = 1'b1;
            nx.rresp = 2'h0;
            unique case (s_axi_araddr)
                `SZBT_OFS_ZONE0:  nx.rdata = {16'h0000, st.cfg0};
                `SZBT_OFS_ZONE1:  nx.rdata = {16'h0000, st.cfg1};
                `SZBT_OFS_ZONE2:  nx.rdata = {16'h0000, st.cfg2};
                `SZBT_OFS_IOZONE: nx.rdata = {16'h0000, st.cfgio};
                `SZBT_OFS_STATUS: nx.rdata = {26'h0, st.last_post, st.last_zone,
                                              st.phase != PH_IDLE, st.second};
                default: begin
                    nx.rdata = 32'h0000_0000;
                    nx.rresp = 2'h2;
                end
            endcase
        end
        nx.arready = !nx.rvalid;

        // bus cycle sequencer
        unique case (st.phase)
            PH_IDLE: begin
                if (cpu_req.valid && !st.cpu_done) begin
                    changed = p.zone != st.last_zone;
                    nx.plan = p;
                    nx.plan.pre_always = p.pre_always || (changed && p.pre_cfg);
                    nx.second = 1'b0;
                    if (changed && st.last_post) begin
                        nx.phase = PH_POST;
                    end else if (nx.plan.pre_always) begin
                        nx.phase = PH_PRE;
                    end else begin
                        nx.phase = PH_BASE;
                        nx.cnt = {2'h0, p.base - 2'h1};
                    end
                end
            end
            PH_POST: begin
                if (st.plan.pre_always) begin
                    nx.phase = PH_PRE;
                end else begin
                    nx.phase = PH_BASE;
                    nx.cnt = {2'h0, st.plan.base - 2'h1};
                end
            end
            PH_PRE: begin
                nx.phase = PH_BASE;
                nx.cnt = {2'h0, st.plan.base - 2'h1};
            end
            PH_BASE: begin
                if (st.cnt != 4'h0) begin
                    nx.cnt = st.cnt - 4'h1;
                end else begin
                    sq = step(st.plan, st.second, 2'd0);
                end
            end
            PH_WAIT: begin
                if (st.cnt != 4'h0) begin
                    nx.cnt = st.cnt - 4'h1;
                end else begin
                    sq = step(st.plan, st.second, 2'd1);
                end
            end
            PH_HOLD: begin
                if (st.cnt != 4'h0) begin
                    nx.cnt = st.cnt - 4'h1;
                end else begin
                    sq = step(st.plan, st.second, 2'd2);
                end
            end
            PH_BURST: begin
                if (st.cnt != 4'h0) begin
                    nx.cnt = st.cnt - 4'h1;
                end else begin
                    sq = step(st.plan, st.second, 2'd3);
                end
            end
        endcase
        if (st.phase != PH_IDLE && st.phase != PH_POST && st.phase != PH_PRE
            && st.cnt == 4'h0) begin
            nx.phase = sq.phase;
            nx.cnt = sq.cnt;
            nx.second = sq.second;
            if (sq.done) begin
                nx.cpu_done = 1'b1;
                nx.last_zone = st.plan.zone;
                nx.last_post = st.plan.post_cfg;
            end
        end

        // bus pins follow the next phase so they leave flops
        active = nx.phase == PH_BASE || nx.phase == PH_WAIT ||
                 nx.phase == PH_HOLD || nx.phase == PH_BURST;
        offchip = nx.plan.zone == ZN_ZONE1 || nx.plan.zone == ZN_ZONE2 ||
                  nx.plan.zone == ZN_IO;
        nx.bus.zone1_select = active && nx.plan.zone == ZN_ZONE1;
        nx.bus.zone2_select = active && nx.plan.zone == ZN_ZONE2;
        nx.bus.ext_read = active && nx.phase != PH_HOLD && offchip && !nx.plan.write;
        nx.bus.ext_write = active && nx.phase != PH_HOLD && offchip && nx.plan.write;
        nx.bus.upper_byte = active && nx.second;
        nx.bus.idle_cycle = nx.phase == PH_PRE || nx.phase == PH_POST;
        nx.bus.busy = nx.phase != PH_IDLE;
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
            st.phase <= PH_IDLE;
            st.last_zone <= ZN_NONE;
            st.cfg0 <= `SZBT_RST_ZONE0;
            st.cfg1 <= `SZBT_RST_ZONE1;
            st.cfg2 <= `SZBT_RST_ZONE2;
            st.cfgio <= `SZBT_RST_IOZONE;
            st.awready <= 1'b1;
            st.wready <= 1'b1;
            st.arready <= 1'b1;
        end else begin
            st <= nx;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign s_axi_awready = st.awready;
    assign s_axi_wready = st.wready;
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_bresp = st.bresp;
    assign s_axi_arready = st.arready;
    assign s_axi_rvalid = st.rvalid;
    assign s_axi_rdata = st.rdata;
    assign s_axi_rresp = st.rresp;
    assign cpu_done = st.cpu_done;
    assign bus_out = st.bus;

endmodule

// [verif/szbt_properties.sv]
`timescale 1ns/1ps
module szbt_properties (
    input wire logic                    aclk,
    input wire logic                    aresetn,
    input wire logic                    s_axi_awvalid,
    input wire logic                    s_axi_awready,
    input wire logic                    s_axi_wvalid,
    input wire logic                    s_axi_wready,
    input wire logic                    s_axi_bvalid,
    input wire logic                    s_axi_arvalid,
    input wire logic                    s_axi_arready,
    input wire logic                    s_axi_rvalid,
    input wire szbt_pkg::szbt_cpu_req_t cpu_req,
    input wire logic                    cpu_done,
    input wire szbt_pkg::szbt_bus_out_t bus_out
);
    import szbt_pkg::*;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic       take;
    logic       ram;
    logic       per;
    logic [4:0] run;
    logic [23:0] a;
    // request acceptance and on-chip range decode
    assign a = cpu_req.addr;
    assign take = cpu_req.valid && !bus_out.busy && !cpu_done;
    assign ram = (a >= 24'h0e8000 && a <= 24'h0e91ff) || (a >= 24'h0ec000 && a <= 24'h0eebff);
    assign per = (a >= 24'h0ef000 && a <= 24'h0ef1ff) || (a >= 24'hff0000 && a <= 24'hfffaff);
    // length of the current select run
    always_ff @(posedge aclk) begin
        if (!aresetn || !(bus_out.zone1_select || bus_out.zone2_select)) begin
            run <= 5'h00;
        end else if (run != 5'h1f) begin
            run <= run + 5'h01;
        end
    end
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_b_answer;
        !s_axi_bvalid ##1 s_axi_bvalid;
    endsequence
    a_ram_single: assert property (take && ram |-> ##2 cpu_done)
        else $error("ram access not single cycle");
    a_periph_idle: assert property (take && per |=> bus_out.idle_cycle)
        else $error("peripheral access without leading idle");
    a_idle_quiet: assert property (bus_out.idle_cycle |-> !(bus_out.zone1_select
        || bus_out.zone2_select || bus_out.ext_read || bus_out.ext_write))
        else $error("strobe during idle cycle");
    a_one_select: assert property (!(bus_out.zone1_select && bus_out.zone2_select))
        else $error("both zone selects high");
    a_select_bound: assert property (run <= 5'h18)
        else $error("select run too long");
    a_done_bound: assert property ($rose(bus_out.busy) |-> ##[1:40] cpu_done)
        else $error("access did not complete");
    a_done_pulse: assert property (cpu_done |=> !cpu_done)
        else $error("done longer than one cycle");
    a_upper_busy: assert property (bus_out.upper_byte |-> bus_out.busy)
        else $error("upper byte outside access");
    a_wr_answer: assert property (s_wr_taken |=> s_b_answer)
        else $error("write response late");
    a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
endmodule

bind szbt_top szbt_properties i_szbt_properties (.aclk, .aresetn, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .cpu_req, .cpu_done, .bus_out);

// [verif/szbt_ext_mem.sv]
`timescale 1ns/1ps
module szbt_ext_mem (
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    input  wire szbt_pkg::szbt_bus_out_t bus_out,
    output logic [4:0]                   strobe_cnt
);
    import szbt_pkg::*;
    logic busy_q;
    // strobe cycles seen by the device during the access under way
    always_ff @(posedge aclk) begin
        busy_q <= bus_out.busy;
        if (!aresetn) begin
            strobe_cnt <= 5'h00;
        end else if (bus_out.busy && !busy_q) begin
            strobe_cnt <= {4'h0, bus_out.ext_read | bus_out.ext_write};
        end else if (bus_out.ext_read || bus_out.ext_write) begin
            strobe_cnt <= strobe_cnt + 5'h01;
        end
    end
endmodule

// [verif/szbt_top_test.sv]
`timescale 1ns/1ps
module szbt_top_test;
    import szbt_pkg::*;
    logic          aclk, aresetn, cpu_done;
    logic [7:0]    s_axi_awaddr, s_axi_araddr;
    logic [31:0]   s_axi_wdata, s_axi_rdata, rd;
    logic [3:0]    s_axi_wstrb;
    logic          s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic          s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic          s_axi_rvalid, s_axi_rready;
    logic [1:0]    s_axi_bresp, s_axi_rresp, resp;
    szbt_cpu_req_t cpu_req;
    szbt_bus_out_t bus_out;
    logic [4:0]    strobe_cnt;
    int            error_cnt, total_checks, cycles, n, z;

    szbt_top i_szbt_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cpu_req, .cpu_done,
        .bus_out);
    szbt_ext_mem i_szbt_ext_mem (.aclk, .aresetn, .bus_out, .strobe_cnt);

    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    // hang guard
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            results();
        end
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task results;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task axi_wr(input logic [7:0] a, input logic [15:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= {16'h0000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask
    task axi_rd(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask
    // one cpu access; n counts edges until done is seen
    task acc(input logic [23:0] a, input logic [1:0] k);
        n = 0;
        cpu_req <= '{1'b1, a, k[1], k[0]};
        do begin
            @(posedge aclk);
            n++;
        end while (cpu_done !== 1'b1);
        cpu_req <= '0;
        @(posedge aclk);
    endtask
    task t_regs;
        axi_rd(8'h08);
        chk(rd, 32'h0000069f, "zone2 cfg reset");
        axi_wr(8'h04, 16'hffff);
        axi_rd(8'h04);
        chk(rd, 32'h00000eff, "zone1 cfg mask");
        axi_wr(8'h40, 16'h1234);
        chk(resp, 2'b10, "unmapped write");
        axi_rd(8'h40);
        chk(resp, 2'b10, "unmapped read");
    endtask
    task t_onchip;
        int f;
        acc(24'h0e8000, 2'h0);
        chk(n, 3, "ram read");
        acc(24'h0eebfe, 2'h3);
        chk(n, 3, "ram write");
        axi_wr(8'h00, 16'h0880);
        acc(24'h000000, 2'h0);
        f = n;
        acc(24'h03fffe, 2'h2);
        chk(n, f + 1, "flash fast write");
        axi_wr(8'h00, 16'h0893);
        acc(24'h000010, 2'h0);
        chk(n, f, "flash fast read");
        axi_wr(8'h00, 16'h0093);
        acc(24'h0e0000, 2'h0);
        chk(n, f + 6, "flash read");
        acc(24'h0e1ffe, 2'h2);
        chk(n, f + 6, "flash late write");
        axi_wr(8'h00, 16'h1093);
        acc(24'h000020, 2'h2);
        chk(n, f + 7, "flash early write");
        acc(24'h0ef000, 2'h0);
        chk(n, f + 2, "periph read");
        acc(24'hff0000, 2'h2);
        chk(n, f + 2, "periph write");
    endtask
    task t_zone;
        axi_wr(8'h08, 16'h0080);
        acc(24'h200000, 2'h0);
        z = n;
        chk(strobe_cnt, 2, "zone2 strobes");
        axi_wr(8'h08, 16'h009f);
        acc(24'h200004, 2'h0);
        chk(n, z + 10, "wait and hold");
        chk(strobe_cnt, 9, "wait strobes");
        axi_wr(8'h04, 16'h089f);
        acc(24'h100000, 2'h0);
        chk(n, z - 1, "fast read");
        chk(strobe_cnt, 1, "fast strobes");
        acc(24'h100002, 2'h2);
        chk(n, z, "zone1 write");
        axi_wr(8'h08, 16'h0020);
        acc(24'h200000, 2'h1);
        chk(n, z + 1, "burst");
        axi_wr(8'h08, 16'h0060);
        acc(24'h200000, 2'h1);
        chk(n, z + 2, "burst wait");
        axi_wr(8'h08, 16'h0000);
        acc(24'h200000, 2'h1);
        chk(n, z + 2, "byte split");
        axi_wr(8'h08, 16'h0080);
        acc(24'h200000, 2'h1);
        chk(n, z, "word single");
    endtask
    task t_idle;
        axi_wr(8'h04, 16'h0480);
        acc(24'h100000, 2'h0);
        chk(n, z + 1, "idle before");
        axi_wr(8'h04, 16'h0280);
        acc(24'h100000, 2'h0);
        chk(n, z, "same zone");
        acc(24'h200000, 2'h0);
        chk(n, z + 1, "idle after");
        acc(24'h200000, 2'h0);
        chk(n, z, "no change");
        axi_wr(8'h0c, 16'h0080);
        acc(24'hfffb00, 2'h0);
        chk(n, z, "io zone");
    endtask
    initial begin
        aresetn = 1'b0;
        cpu_req = '0;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'h3;
        s_axi_awvalid = 1'b0;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_regs();
        t_onchip();
        t_zone();
        t_idle();
        results();
    end
endmodule
